/* logic/timer_defs.svh */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADR_CTRL       4'h0
`define ADR_CNT_HI     4'h1
`define ADR_CNT_LO     4'h2
`define ADR_MOD_HI     4'h3
`define ADR_MOD_LO     4'h4
`define ADR_CH0_CTRL   4'h5
`define ADR_CH_STRIDE  4'h3
`define ADR_VAL_HI     4'h1
`define ADR_VAL_LO     4'h2

// ****************************************
// Field positions
// ****************************************
`define CTRL_FLAG      7
`define CTRL_IE        6
`define CTRL_STOP      5
`define CTRL_CLR       4
`define CTRL_PS_HI     2
`define CTRL_PS_LO     0
`define CH_FLAG        7
`define CH_IE          6
`define CH_LINK        5
`define CH_MODEA       4
`define CH_ELS_HI      3
`define CH_ELS_LO      2
`define CH_TOV         1

// ****************************************
// Encodings and reset values
// ****************************************
`define PS_EXT         3'h7
`define PS_RST         3'h0
`define MOD_RST        16'hFFFF
`define VAL_RST        16'h0000
`define CNT_RST        16'h0000
`define ELS_OFF        2'h0
`define ELS_A          2'h1
`define ELS_B          2'h2
`define ELS_AB         2'h3
`define PIN_CH0        0
`define PIN_CH1        1
`define PIN_CLK        2

`endif

/* logic/timer_pkg.sv */
package timer_pkg;

  typedef struct packed {
    logic       irq_en;
    logic       link;
    logic       mode_a;
    logic [1:0] els;
    logic       tov;
  } ch_cfg_s;

  typedef struct packed {
    logic capture;
    logic match;
  } ch_evt_s;

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] raw_in,
  output var  logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

/* logic/timer_channel.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_channel #(
  parameter int CW = 16
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire timer_pkg::ch_cfg_s cfg_in,
  input  wire logic [CW-1:0]     value_in,
  input  wire logic [CW-1:0]     count_in,
  input  wire logic              count_upd_in,
  input  wire logic              ovf_in,
  input  wire logic              run_in,
  input  wire logic              pin_lvl_in,
  output var  timer_pkg::ch_evt_s evt_out,
  output var  logic              drive_lvl_out
);
  import timer_pkg::*;
  `include "timer_defs.svh"

  logic pin_prev_r;
  logic rise;
  logic fall;
  logic is_cmp;
  logic is_cap;
  logic lvl_nxt;

  // Link has priority over mode select A
  assign is_cmp = cfg_in.link | cfg_in.mode_a;
  assign is_cap = ~is_cmp;
  assign rise   = pin_lvl_in & ~pin_prev_r;
  assign fall   = ~pin_lvl_in & pin_prev_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_lvl_in;
    end
  end

  always_comb begin
    evt_out.capture = 1'b0;
    if (is_cap && run_in) begin
      unique case (cfg_in.els)
        `ELS_A:  evt_out.capture = rise;
        `ELS_B:  evt_out.capture = fall;
        `ELS_AB: evt_out.capture = rise | fall;
        default: evt_out.capture = 1'b0;
      endcase
    end
    // Live compare: a value already passed waits a full period
    evt_out.match = is_cmp & count_upd_in & (count_in == value_in);
  end

  always_comb begin
    lvl_nxt = drive_lvl_out;
    if (evt_out.match) begin
      unique case (cfg_in.els)
        `ELS_A:  lvl_nxt = ~drive_lvl_out;
        `ELS_B:  lvl_nxt = 1'b0;
        `ELS_AB: lvl_nxt = 1'b1;
        default: lvl_nxt = drive_lvl_out;
      endcase
    end
    if (ovf_in && cfg_in.tov && is_cmp) begin
      lvl_nxt = ~lvl_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_lvl_out <= 1'b0;
    end else begin
      drive_lvl_out <= lvl_nxt;
    end
  end

endmodule

`default_nettype wire

/* logic/timer_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_unit #(
  parameter int CW = 16,
  parameter int NP = 3
) (
  input  wire logic          CLK_IN,
  input  wire logic          RST_N_IN,
  input  wire logic [3:0]    ADDR_IN,
  input  wire logic [7:0]    WDATA_IN,
  input  wire logic          WR_IN,
  input  wire logic          RD_IN,
  output var  logic [7:0]    RDATA_OUT,
  input  wire logic [NP-1:0] PORT_A_OUT_IN,
  input  wire logic [NP-1:0] PORT_A_OE_IN,
  input  wire logic [NP-1:0] PIN_IN,
  output var  logic [NP-1:0] PIN_OUT,
  output var  logic [NP-1:0] PIN_OE_OUT,
  output var  logic          IRQ_OVF_OUT,
  output var  logic [1:0]    IRQ_CH_OUT
);
  import timer_pkg::*;
  `include "timer_defs.svh"

  // ****************************************
  // Declarations
  // ****************************************
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   mod_r;
  logic [CW-1:0]   val_r [2];
  logic [5:0]      pre_r;
  logic [5:0]      pre_mask;
  logic [2:0]      ps_r;
  logic            stop_r;
  logic            ovf_flag_r;
  logic            ovf_ie_r;
  logic            upd_r;
  logic            tick;
  logic            clr;
  logic            ext_prev_r;
  logic            ovf_evt;
  logic            active_r;
  logic            last_wr_r;
  logic            link;
  logic [NP-1:0]   pin_lvl;
  logic [1:0]      ch_flag_r;
  ch_cfg_s         cfg_r [2];
  ch_cfg_s         cfg_eff [2];
  ch_evt_s         evt [2];
  logic [1:0]      drive_lvl;
  logic [CW-1:0]   cmp_val [2];
  logic [7:0]      rd_mux;
  logic [1:0]      wr_ctl;
  logic [1:0]      wr_hi;
  logic [1:0]      wr_lo;
  logic [1:0]      rd_ctl;
  logic [1:0]      rd_hi;
  logic [1:0]      rd_lo;
  logic [1:0]      own_out;

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wr_ctl[i] = WR_IN && (ADDR_IN == 4'(`ADR_CH0_CTRL + i * `ADR_CH_STRIDE));
      wr_hi[i]  = WR_IN && (ADDR_IN == 4'(`ADR_CH0_CTRL + i * `ADR_CH_STRIDE + `ADR_VAL_HI));
      wr_lo[i]  = WR_IN && (ADDR_IN == 4'(`ADR_CH0_CTRL + i * `ADR_CH_STRIDE + `ADR_VAL_LO));
      rd_ctl[i] = (ADDR_IN == 4'(`ADR_CH0_CTRL + i * `ADR_CH_STRIDE));
      rd_hi[i]  = (ADDR_IN == 4'(`ADR_CH0_CTRL + i * `ADR_CH_STRIDE + `ADR_VAL_HI));
      rd_lo[i]  = (ADDR_IN == 4'(`ADR_CH0_CTRL + i * `ADR_CH_STRIDE + `ADR_VAL_LO));
    end
  end

  assign clr = WR_IN && (ADDR_IN == `ADR_CTRL) && WDATA_IN[`CTRL_CLR];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pin_sync #(
    .WIDTH    (NP)
  ) u_sync (
    .clk_in    (CLK_IN),
    .rst_n_in  (RST_N_IN),
    .raw_in    (PIN_IN),
    .level_out (pin_lvl)
  );

  // ****************************************
  // Prescaler
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pre_r      <= '0;
      ext_prev_r <= 1'b0;
    end else begin
      pre_r      <= clr ? 6'h00 : 6'(pre_r + 6'h01);
      ext_prev_r <= pin_lvl[`PIN_CLK];
    end
  end

  // Divide by 2**select; the top code takes the external pin's rising edge
  assign pre_mask = 6'((7'h01 << ps_r) - 7'h01);
  assign tick     = (ps_r == `PS_EXT) ? (pin_lvl[`PIN_CLK] & ~ext_prev_r)
                                      : ((pre_r & pre_mask) == pre_mask);

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt_r <= `CNT_RST;
      upd_r <= 1'b0;
    end else begin
      upd_r <= tick & ~stop_r & ~clr;
      if (clr) begin
        cnt_r <= `CNT_RST;
      end else if (tick && !stop_r) begin
        // Natural wrap covers a limit written below the count
        cnt_r <= (cnt_r == mod_r) ? `CNT_RST : CW'(cnt_r + 1'b1);
      end
    end
  end

  assign ovf_evt = upd_r & (cnt_r == mod_r);

  // ****************************************
  // Global control
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ps_r     <= `PS_RST;
      stop_r   <= 1'b1;
      ovf_ie_r <= 1'b0;
      mod_r    <= `MOD_RST;
    end else begin
      if (WR_IN && ADDR_IN == `ADR_CTRL) begin
        ps_r     <= WDATA_IN[`CTRL_PS_HI:`CTRL_PS_LO];
        stop_r   <= WDATA_IN[`CTRL_STOP];
        ovf_ie_r <= WDATA_IN[`CTRL_IE];
      end
      if (WR_IN && ADDR_IN == `ADR_MOD_HI) begin
        mod_r[15:8] <= WDATA_IN;
      end
      if (WR_IN && ADDR_IN == `ADR_MOD_LO) begin
        mod_r[7:0] <= WDATA_IN;
      end
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_r <= 1'b1;
    end else if (WR_IN && ADDR_IN == `ADR_CTRL && !WDATA_IN[`CTRL_FLAG]) begin
      ovf_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Channel control and values
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < 2; i++) begin
        cfg_r[i] <= '0;
        val_r[i] <= `VAL_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ctl[i]) begin
          cfg_r[i].irq_en <= WDATA_IN[`CH_IE];
          cfg_r[i].link   <= (i == 0) ? WDATA_IN[`CH_LINK] : 1'b0;
          cfg_r[i].mode_a <= WDATA_IN[`CH_MODEA];
          cfg_r[i].els    <= WDATA_IN[`CH_ELS_HI:`CH_ELS_LO];
          cfg_r[i].tov    <= WDATA_IN[`CH_TOV];
        end
        if (evt[i].capture) begin
          val_r[i] <= cnt_r;
        end else begin
          if (wr_hi[i]) begin
            val_r[i][15:8] <= WDATA_IN;
          end
          if (wr_lo[i]) begin
            val_r[i][7:0] <= WDATA_IN;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ch_flag_r <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (evt[i].capture || evt[i].match) begin
          ch_flag_r[i] <= 1'b1;
        end else if (wr_ctl[i] && !WDATA_IN[`CH_FLAG]) begin
          ch_flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Buffered link
  // ****************************************
  assign link = cfg_r[0].link;

  // Active pair follows the last written pair, switched only at overflow
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      active_r  <= 1'b0;
      last_wr_r <= 1'b0;
    end else if (!link) begin
      active_r  <= 1'b0;
      last_wr_r <= 1'b0;
    end else begin
      if (wr_hi[1] || wr_lo[1]) begin
        last_wr_r <= 1'b1;
      end else if (wr_hi[0] || wr_lo[0]) begin
        last_wr_r <= 1'b0;
      end
      if (ovf_evt) begin
        active_r <= last_wr_r;
      end
    end
  end

  // Channel 1 control is dead while linked
  assign cfg_eff[0] = cfg_r[0];
  assign cfg_eff[1] = link ? ch_cfg_s'('0) : cfg_r[1];
  assign cmp_val[0] = (link && active_r) ? val_r[1] : val_r[0];
  assign cmp_val[1] = val_r[1];

  // ****************************************
  // Channels
  // ****************************************
  for (genvar g = 0; g < 2; g++) begin : g_ch
    timer_channel #(
      .CW (CW)
    ) u_ch (
      .clk_in        (CLK_IN),
      .rst_n_in      (RST_N_IN),
      .cfg_in        (cfg_eff[g]),
      .value_in      (cmp_val[g]),
      .count_in      (cnt_r),
      .count_upd_in  (upd_r),
      .ovf_in        (ovf_evt),
      .run_in        (~stop_r),
      .pin_lvl_in    (pin_lvl[g]),
      .evt_out       (evt[g]),
      .drive_lvl_out (drive_lvl[g])
    );
  end

  // ****************************************
  // Pin sharing
  // ****************************************
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      own_out[i] = (cfg_eff[i].link | cfg_eff[i].mode_a) & (cfg_eff[i].els != `ELS_OFF);
    end
  end

  // Timer drives a pin while a compare action is set; an armed capture or the external clock forces its enable low
  always_comb begin
    PIN_OUT    = PORT_A_OUT_IN;
    PIN_OE_OUT = PORT_A_OE_IN;
    for (int i = 0; i < 2; i++) begin
      if (own_out[i]) begin
        PIN_OUT[i]    = drive_lvl[i];
        PIN_OE_OUT[i] = 1'b1;
      end else if (cfg_eff[i].els != `ELS_OFF) begin
        PIN_OE_OUT[i] = 1'b0;
      end
    end
    if (ps_r == `PS_EXT) begin
      PIN_OE_OUT[`PIN_CLK] = 1'b0;
    end
  end

  assign IRQ_OVF_OUT = ovf_flag_r & ovf_ie_r;
  assign IRQ_CH_OUT[0] = ch_flag_r[0] & cfg_eff[0].irq_en;
  assign IRQ_CH_OUT[1] = ch_flag_r[1] & cfg_eff[1].irq_en;

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR_IN)
      `ADR_CTRL:   rd_mux = {ovf_flag_r, ovf_ie_r, stop_r, 2'h0, ps_r};
      `ADR_CNT_HI: rd_mux = cnt_r[15:8];
      `ADR_CNT_LO: rd_mux = cnt_r[7:0];
      `ADR_MOD_HI: rd_mux = mod_r[15:8];
      `ADR_MOD_LO: rd_mux = mod_r[7:0];
      default:     rd_mux = 8'h00;
    endcase
    for (int i = 0; i < 2; i++) begin
      if (rd_ctl[i]) begin
        rd_mux = {ch_flag_r[i], cfg_r[i].irq_en, cfg_r[i].link, cfg_r[i].mode_a,
                  cfg_r[i].els, cfg_r[i].tov, 1'b0};
      end else if (rd_hi[i]) begin
        rd_mux = val_r[i][15:8];
      end else if (rd_lo[i]) begin
        rd_mux = val_r[i][7:0];
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence s_wrap_tick;
    tick && !stop_r && !clr && (cnt_r == mod_r);
  endsequence

  property p_wrap;
    s_wrap_tick |=> (cnt_r == `CNT_RST) ##0 (upd_r && !ovf_evt);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_stop_hold;
    stop_r && !clr |=> $stable(cnt_r) && !ovf_evt && !evt[0].match;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");

  property p_read_clean;
    RD_IN && !tick && !clr |=> $stable(cnt_r);
  endproperty
  a_read_clean: assert property (p_read_clean) else $error("read disturbed count");

  property p_ovf_flag;
    ovf_evt |=> ovf_flag_r ##0 (IRQ_OVF_OUT == ovf_ie_r);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing");

  property p_capture;
    evt[0].capture |=> (val_r[0] == $past(cnt_r)) && ch_flag_r[0];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_fast_tick;
    ps_r == `PS_RST |-> tick;
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("prescaler rate wrong");

  property p_ch1_free;
    link |-> (PIN_OE_OUT[1] == PORT_A_OE_IN[1]) && !evt[1].match && !evt[1].capture;
  endproperty
  a_ch1_free: assert property (p_ch1_free) else $error("channel1 pin held");

  property p_link_switch;
    link && ovf_evt && last_wr_r && !wr_ctl[0] |=> active_r;
  endproperty
  a_link_switch: assert property (p_link_switch) else $error("pair not switched");

  property p_set_match;
    evt[0].match && cfg_eff[0].els == `ELS_AB && !(ovf_evt && cfg_eff[0].tov)
      |=> drive_lvl[0] ##1 (PIN_OE_OUT[0] || !own_out[0]);
  endproperty
  a_set_match: assert property (p_set_match) else $error("set on match failed");

endmodule

`default_nettype wire

/* bench/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
  input  wire logic [2:0] drv_en_in,
  input  wire logic [2:0] drv_lvl_in,
  input  wire logic [2:0] pin_out_in,
  input  wire logic [2:0] pin_oe_in,
  output var  logic [2:0] pad_out
);

  // ****************************************
  // Pad resolution
  // ****************************************
  // Pull-up on every pad, so a released pad never shows a stale level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe_in[i]) begin
        pad_out[i] = pin_out_in[i];
      end else if (drv_en_in[i]) begin
        pad_out[i] = drv_lvl_in[i];
      end else begin
        pad_out[i] = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* bench/two_channel_capture_compare_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"

module two_channel_capture_compare_timer_tb;

  localparam logic [3:0] CT = `ADR_CTRL;
  localparam logic [3:0] LO = `ADR_CNT_LO;
  localparam logic [3:0] MH = `ADR_MOD_HI;
  localparam logic [3:0] ML = `ADR_MOD_LO;
  localparam logic [3:0] C0 = `ADR_CH0_CTRL;
  localparam logic [3:0] C1 = C0 + `ADR_CH_STRIDE;
  localparam logic [3:0] V0 = C0 + `ADR_VAL_LO;
  localparam logic [3:0] V1 = C1 + `ADR_VAL_LO;

  typedef struct packed {
    logic [3:0] a;
    logic       w;
    logic [7:0] d;
  } row_s;

  // Write rows carry data, read rows the expected value
  localparam row_s ROWS [15] = '{
    '{CT, 1'b0, 8'h20}, '{MH, 1'b0, 8'hFF}, '{ML, 1'b0, 8'hFF}, '{C0, 1'b0, 8'h00},
    '{V1, 1'b0, 8'h00}, '{CT, 1'b1, 8'h30}, '{CT, 1'b0, 8'h20}, '{MH, 1'b1, 8'h12},
    '{MH, 1'b0, 8'h12}, '{C1, 1'b1, 8'h7E}, '{C1, 1'b0, 8'h5E}, '{C1, 1'b1, 8'h00},
    '{4'hF, 1'b1, 8'h5A}, '{4'hF, 1'b0, 8'h00}, '{MH, 1'b1, 8'h00}};
  localparam logic [7:0] CM [4] = '{8'h5C, 8'h58, 8'h54, 8'h54};
  localparam logic [3:0] PX = 4'b0101;

  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [2:0] po = 3'b011;
  logic [2:0] poe = 3'b010;
  logic [2:0] drv_en = 3'b111;
  logic [2:0] drv_lvl = 3'b000;
  logic [7:0] rdata;
  logic [2:0] pad;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic       irq_ovf;
  logic [1:0] irq_ch;
  int         bad_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  logic [7:0] q;
  logic [7:0] c;
  logic [7:0] mx;
  logic       z;

  always #5 clk = ~clk;

  timer_unit dut (
    .CLK_IN        (clk),
    .RST_N_IN      (rst_n),
    .ADDR_IN       (addr),
    .WDATA_IN      (wdata),
    .WR_IN         (wr),
    .RD_IN         (rd),
    .RDATA_OUT     (rdata),
    .PORT_A_OUT_IN (po),
    .PORT_A_OE_IN  (poe),
    .PIN_IN        (pad),
    .PIN_OUT       (pin_out),
    .PIN_OE_OUT    (pin_oe),
    .IRQ_OVF_OUT   (irq_ovf),
    .IRQ_CH_OUT    (irq_ch)
  );

  pin_partner ext (
    .drv_en_in  (drv_en),
    .drv_lvl_in (drv_lvl),
    .pin_out_in (pin_out),
    .pin_oe_in  (pin_oe),
    .pad_out    (pad)
  );

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Polls a flag bit; bounded so a dead flag cannot hang the run
  task automatic wait_bit(input logic [3:0] a, input int b);
    logic [7:0] d;
    int         n;
    n = 0;
    rd_reg(a, d);
    while (d[b] !== 1'b1 && n < 200) begin
      rd_reg(a, d);
      n++;
    end
    chk(d[b], 1'b1);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) begin
        wr_reg(ROWS[i].a, ROWS[i].d);
      end else begin
        rd_reg(ROWS[i].a, q);
        chk(q, ROWS[i].d);
      end
    end
    for (int p = 0; p < 7; p++) begin
      wr_reg(CT, 8'h30);
      wr_reg(CT, 8'(p));
      repeat (198) @(posedge clk);
      wr_reg(CT, 8'h20);
      rd_reg(LO, q);
      chk(int'(q) >= (200 >> p) - 2 && int'(q) <= (200 >> p) + 2, 1'b1);
      rd_reg(LO, c);
      chk(c, q);
    end
    wr_reg(CT, 8'h30);
    wr_reg(CT, 8'h07);
    repeat (5) begin
      drv_lvl[2] <= 1'b1;
      repeat (4) @(posedge clk);
      drv_lvl[2] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    wr_reg(CT, 8'h27);
    rd_reg(LO, q);
    chk(q, 8'h05);
    wr_reg(ML, 8'h10);
    wr_reg(CT, 8'h10);
    mx = 8'h00;
    z = 1'b0;
    repeat (40) begin
      rd_reg(LO, q);
      mx = (q > mx) ? q : mx;
      z = z | (q == 8'h00);
    end
    chk(mx, 8'h10);
    chk(z, 1'b1);
    rd_reg(CT, q);
    chk(q[7], 1'b1);
    chk(irq_ovf, 1'b0);
    wr_reg(CT, 8'h40);
    wait_bit(CT, 7);
    chk(irq_ovf, 1'b1);
    // Compare actions, second channel masked to show gating
    wr_reg(ML, 8'h20);
    wr_reg(V0, 8'h08);
    wr_reg(V1, 8'h08);
    wr_reg(C1, 8'h1C);
    for (int i = 0; i < 4; i++) begin
      wr_reg(C0, CM[i]);
      wait_bit(C0, 7);
      chk(pin_out[0], PX[i]);
      chk({pin_oe[0], irq_ch[0]}, 2'b11);
    end
    rd_reg(C1, q);
    chk({q[7], irq_ch[1]}, 2'b10);
    wr_reg(C1, 8'h00);
    wr_reg(C0, 8'h5A);
    wr_reg(CT, 8'h00);
    wait_bit(CT, 7);
    repeat (2) @(posedge clk);
    chk(pin_out[0], 1'b1);
    // Unbuffered rewrites timed from the matching interrupt source
    wr_reg(V0, 8'h10);
    wr_reg(C0, 8'h5A);
    wait_bit(C0, 7);
    rd_reg(LO, q);
    chk(q >= 8'h10 && q <= 8'h18, 1'b1);
    wr_reg(V0, 8'h08);
    wr_reg(C0, 8'h5A);
    wait_bit(C0, 7);
    rd_reg(LO, q);
    chk(q >= 8'h08 && q <= 8'h10, 1'b1);
    // Captures: slow count keeps the stamp steady around the edge
    wr_reg(C0, 8'h00);
    wr_reg(CT, 8'h06);
    repeat (8) @(posedge clk);
    for (int e = 1; e < 4; e++) begin
      wr_reg(C0, {4'h4, 2'(e), 2'b00});
      rd_reg(LO, c);
      drv_lvl[0] <= 1'b1;
      repeat (8) @(posedge clk);
      rd_reg(C0, q);
      chk({q[7], irq_ch[0]}, {2{e[0]}});
      rd_reg(V0, q);
      if (e == 1) chk(8'(q - c) <= 8'h01, 1'b1);
      wr_reg(C0, {4'h4, 2'(e), 2'b00});
      drv_lvl[0] <= 1'b0;
      repeat (8) @(posedge clk);
      rd_reg(C0, q);
      chk({q[7], irq_ch[0]}, {2{e[1]}});
    end
    // Linked pair; second control register must stay inert
    wr_reg(CT, 8'h30);
    wr_reg(ML, 8'h40);
    wr_reg(V0, 8'h08);
    wr_reg(C0, 8'h3A);
    wr_reg(C1, 8'h5C);
    wr_reg(CT, 8'h00);
    chk({pin_oe[1], pin_out[1]}, {poe[1], po[1]});
    wait_bit(C0, 7);
    rd_reg(LO, q);
    chk(q >= 8'h08 && q <= 8'h10, 1'b1);
    wr_reg(V1, 8'h30);
    wr_reg(C0, 8'h3A);
    wr_reg(CT, 8'h00);
    wait_bit(CT, 7);
    wr_reg(C0, 8'h3A);
    wait_bit(C0, 7);
    rd_reg(LO, q);
    chk(q >= 8'h30 && q <= 8'h38, 1'b1);
    chk(irq_ch[1], 1'b0);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({pin_oe, pin_out}, {poe, po});
    rst_n <= 1'b1;
    print_verdict();
  end

endmodule

`default_nettype wire
